// [cpc_cfg.svh]
// offsets, field positions, reset values and timing counts of the clock control
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH

`define CPC_ADR_W          8
`define CPC_OFS_CPU_CTRL   8'h00
`define CPC_OFS_PCIE_CTRL  8'h04
`define CPC_OFS_DISP_CTRL  8'h08
`define CPC_OFS_STATUS     8'h0c

`define CPC_F_OE           0
`define CPC_F_SLEEP        1
`define CPC_F_HALT         2
`define CPC_F_AON          3
`define CPC_NIB            4
`define CPC_F_PERIPH_HALT  4
`define CPC_F_FREE_AON     5

`define CPC_RST_CPU_CTRL   12'h111
`define CPC_RST_PCIE_CTRL  7'h01
`define CPC_RST_DISP_CTRL  2'h1

`define CPC_BIAS_OFF       2'h0
`define CPC_BIAS_NORM      2'h1
`define CPC_BIAS_X6        2'h2
`define CPC_BIAS_X2        2'h3

`define CPC_CLK_PERIOD_NS  10
`define CPC_LOCK_TIME_NS   1000
`define CPC_HALF_CPU       1
`define CPC_HALF_PCIE      2
`define CPC_HALF_DISP      2
`define CPC_HALF_PERIPH    6
`define CPC_HALF_USB       4
`define CPC_HALF_REF       14

`endif

// [cpc_pkg.sv]
// types shared by the clock output control
package cpc_pkg;

    typedef enum logic [3:0] {
        PS_RUN  = 4'b0001,
        PS_PARK = 4'b0010,
        PS_OFF  = 4'b0100,
        PS_WAKE = 4'b1000
    } cpc_pwr_t;

    typedef enum logic [3:0] {
        DM_RUN   = 4'b0001,
        DM_STOP  = 4'b0010,
        DM_PD    = 4'b0100,
        DM_FLOAT = 4'b1000
    } cpc_dmode_t;

    typedef struct packed {
        logic       tru;
        logic       cmp;
        logic       tru_oe;
        logic       cmp_oe;
        logic [1:0] bias;
    } cpc_diff_t;

endpackage

// [cpc_clkdiv.sv]
// divider that makes one raw output clock while the vco runs
`timescale 1ns/1ps
module cpc_clkdiv #(
    parameter int HALF = 2
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    output logic      clk_o
);
    logic [15:0] cnt_reg;

    // phase is kept while stopped so the restart has no short cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0000;
        end else if (run_i) begin
            if (cnt_reg == 16'(HALF - 1)) begin
                cnt_reg <= 16'h0000;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_o <= 1'b0;
        end else if (run_i && cnt_reg == 16'(HALF - 1)) begin
            clk_o <= ~clk_o;
        end
    end
endmodule

// [cpc_top.sv]
// clock output power-down and stop control with wishbone registers
`timescale 1ns/1ps
`include "cpc_cfg.svh"

module cpc_top #(
    parameter int NPB      = 6,
    parameter int LOCK_CYC = (`CPC_LOCK_TIME_NS + `CPC_CLK_PERIOD_NS - 1)
                             / `CPC_CLK_PERIOD_NS
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    power_down_pin_i,
    input  wire logic                    cpu_halt_n_i,
    input  wire logic                    periph_halt_n_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [`CPC_ADR_W-1:0]   wb_adr_i,
    input  wire logic [31:0]             wb_dat_i,
    input  wire logic [3:0]              wb_sel_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         vco_en_o,
    output cpc_pkg::cpc_diff_t [2:0]     cpu_clk_o,
    output cpc_pkg::cpc_diff_t           pcie_ref_clock_o,
    output cpc_pkg::cpc_diff_t           display_96m_clock_o,
    output logic      [NPB-1:0]          periph_bus_clk_o,
    output logic      [1:0]              periph_free_clock_o,
    output logic                         usb_clk_o,
    output logic                         ref_clk_o
);
    localparam int ND  = 5;
    localparam int NSE = NPB + 4;
    localparam int NRAW = 6;
    localparam int HALF [NRAW] = '{`CPC_HALF_CPU, `CPC_HALF_PCIE,
                                   `CPC_HALF_DISP, `CPC_HALF_PERIPH,
                                   `CPC_HALF_USB, `CPC_HALF_REF};

    logic [2:0]          meta_reg;
    logic [2:0]          sync_reg;
    logic [11:0]         cpu_ctrl_reg;
    logic [6:0]          pcie_ctrl_reg;
    logic [1:0]          disp_ctrl_reg;
    logic                ack_reg;
    logic [31:0]         dat_reg;
    logic [15:0]         lock_reg;
    logic                vco_en_reg;
    cpc_pkg::cpc_pwr_t   state_reg;
    cpc_pkg::cpc_pwr_t   state_next;
    logic [NRAW-1:0]     raw;
    logic [NSE-1:0]      se_gate_reg;
    logic [NSE-1:0]      se_out_reg;
    logic [NSE-1:0]      se_raw;
    logic [NSE-1:0]      se_stop;
    cpc_pkg::cpc_dmode_t mode_reg [ND];
    cpc_pkg::cpc_diff_t  [ND-1:0] d_out_reg;
    logic [ND-1:0]       d_oe;
    logic [ND-1:0]       d_slp;
    logic [ND-1:0]       d_hf;
    logic [ND-1:0]       d_aon;
    logic [ND-1:0]       d_stop;
    logic [ND-1:0]       d_raw;
    logic [ND-1:0]       d_parked;
    logic                pd_s;
    logic                cpu_halt;
    logic                periph_stop;
    logic                pcie_stop;
    logic                pd_hold;
    logic                req;
    logic                wr;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // pins come from another domain; only sync_reg is read by logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 3'h6;
            sync_reg <= 3'h6;
        end else begin
            meta_reg <= {periph_halt_n_i, cpu_halt_n_i, power_down_pin_i};
            sync_reg <= meta_reg;
        end
    end

    assign pd_s        = sync_reg[0];
    assign cpu_halt    = ~sync_reg[1];
    assign periph_stop = ~sync_reg[2] | pcie_ctrl_reg[`CPC_F_PERIPH_HALT];
    assign pd_hold     = (state_reg != cpc_pkg::PS_RUN);

    // wishbone slave: one wait state, ack held one cycle
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr  = req && wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_ctrl_reg  <= `CPC_RST_CPU_CTRL;
            pcie_ctrl_reg <= `CPC_RST_PCIE_CTRL;
            disp_ctrl_reg <= `CPC_RST_DISP_CTRL;
        end else if (wr) begin
            case (wb_adr_i)
                `CPC_OFS_CPU_CTRL: begin
                    if (wb_sel_i[0]) begin
                        cpu_ctrl_reg[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        cpu_ctrl_reg[11:8] <= wb_dat_i[11:8];
                    end
                end
                `CPC_OFS_PCIE_CTRL: begin
                    if (wb_sel_i[0]) begin
                        pcie_ctrl_reg <= wb_dat_i[6:0];
                    end
                end
                `CPC_OFS_DISP_CTRL: begin
                    if (wb_sel_i[0]) begin
                        disp_ctrl_reg <= wb_dat_i[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // unmapped offsets read zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (req) begin
            case (wb_adr_i)
                `CPC_OFS_CPU_CTRL:  dat_reg <= {20'h00000, cpu_ctrl_reg};
                `CPC_OFS_PCIE_CTRL: dat_reg <= {25'h0000000, pcie_ctrl_reg};
                `CPC_OFS_DISP_CTRL: dat_reg <= {30'h00000000, disp_ctrl_reg};
                `CPC_OFS_STATUS: begin
                    dat_reg <= {24'h000000, state_reg, vco_en_reg,
                                periph_stop, cpu_halt, pd_s};
                end
                default: dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // power-down sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cpc_pkg::PS_RUN: begin
                if (pd_s) begin
                    state_next = cpc_pkg::PS_PARK;
                end
            end
            cpc_pkg::PS_PARK: begin
                if (!pd_s) begin
                    state_next = cpc_pkg::PS_RUN;
                end else if (se_out_reg == '0 && se_gate_reg == '0
                             && &d_parked) begin
                    // open gate could pass a frozen raw high once vco stops
                    state_next = cpc_pkg::PS_OFF;
                end
            end
            cpc_pkg::PS_OFF: begin
                if (!pd_s) begin
                    state_next = cpc_pkg::PS_WAKE;
                end
            end
            cpc_pkg::PS_WAKE: begin
                if (pd_s) begin
                    state_next = cpc_pkg::PS_PARK;
                end else if (lock_reg == 16'(LOCK_CYC)) begin
                    state_next = cpc_pkg::PS_RUN;
                end
            end
            default: state_next = cpc_pkg::PS_PARK;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= cpc_pkg::PS_WAKE;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs stay parked until the vco has had its lock time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_reg <= 16'h0000;
        end else if (state_reg == cpc_pkg::PS_WAKE) begin
            lock_reg <= lock_reg + 16'h0001;
        end else begin
            lock_reg <= 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vco_en_reg <= 1'b1;
        end else begin
            vco_en_reg <= (state_next != cpc_pkg::PS_OFF);
        end
    end

    assign vco_en_o = vco_en_reg;

    generate
        for (genvar g = 0; g < NRAW; g++) begin : g_raw
            cpc_clkdiv #(
                .HALF (HALF[g])
            ) u_div (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .run_i (vco_en_reg),
                .clk_o (raw[g])
            );
        end
    endgenerate

    // controls of the five pairs: cpu0..2, pcie, display
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            d_oe[k]   = cpu_ctrl_reg[`CPC_NIB*k + `CPC_F_OE];
            d_slp[k]  = cpu_ctrl_reg[`CPC_NIB*k + `CPC_F_SLEEP];
            d_hf[k]   = cpu_ctrl_reg[`CPC_NIB*k + `CPC_F_HALT];
            d_aon[k]  = cpu_ctrl_reg[`CPC_NIB*k + `CPC_F_AON];
            d_stop[k] = cpu_halt;
            d_raw[k]  = raw[0];
        end
        d_oe[3]   = pcie_ctrl_reg[`CPC_F_OE];
        d_slp[3]  = pcie_ctrl_reg[`CPC_F_SLEEP];
        d_hf[3]   = pcie_ctrl_reg[`CPC_F_HALT];
        d_aon[3]  = pcie_ctrl_reg[`CPC_F_AON];
        d_stop[3] = pcie_stop;
        d_raw[3]  = raw[1];
        d_oe[4]   = disp_ctrl_reg[`CPC_F_OE];
        d_slp[4]  = disp_ctrl_reg[`CPC_F_SLEEP];
        d_hf[4]   = 1'b0;
        d_aon[4]  = 1'b1;
        d_stop[4] = 1'b0;
        d_raw[4]  = raw[2];
    end

    // pcie stops only once the periph bus clocks are latched low
    assign pcie_stop = periph_stop && (se_out_reg[NPB-1:0] == '0)
                       && (se_gate_reg[NPB-1:0] == '0);

    generate
        for (genvar g = 0; g < ND; g++) begin : g_diff
            cpc_pkg::cpc_dmode_t tgt;

            always_comb begin
                if (!d_oe[g]) begin
                    tgt = cpc_pkg::DM_FLOAT;
                end else if (pd_hold) begin
                    tgt = d_slp[g] ? cpc_pkg::DM_FLOAT : cpc_pkg::DM_PD;
                end else if (d_stop[g] && !d_aon[g]) begin
                    tgt = d_hf[g] ? cpc_pkg::DM_FLOAT : cpc_pkg::DM_STOP;
                end else begin
                    tgt = cpc_pkg::DM_RUN;
                end
            end

            // moves only while the true leg is high, except to float when oe is cleared, so no runt pulse
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mode_reg[g] <= cpc_pkg::DM_FLOAT;
                end else if (!d_oe[g]) begin
                    mode_reg[g] <= cpc_pkg::DM_FLOAT;
                end else if (d_raw[g]) begin
                    mode_reg[g] <= tgt;
                end
            end

            assign d_parked[g] = (mode_reg[g] == cpc_pkg::DM_PD) ||
                                 (mode_reg[g] == cpc_pkg::DM_FLOAT);

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    d_out_reg[g] <= '0;
                end else begin
                    case (mode_reg[g])
                        cpc_pkg::DM_RUN: begin
                            d_out_reg[g] <= {d_raw[g], ~d_raw[g], 1'b1, 1'b1,
                                             `CPC_BIAS_NORM};
                        end
                        cpc_pkg::DM_STOP: begin
                            d_out_reg[g] <= {1'b1, 1'b0, 1'b1, 1'b1,
                                             `CPC_BIAS_X6};
                        end
                        cpc_pkg::DM_PD: begin
                            d_out_reg[g] <= {1'b1, 1'b0, 1'b1, 1'b0,
                                             `CPC_BIAS_X2};
                        end
                        default: begin
                            d_out_reg[g] <= {1'b0, 1'b0, 1'b0, 1'b0,
                                             `CPC_BIAS_OFF};
                        end
                    endcase
                end
            end

            enable_float_a: assert property (
                (!d_oe[g]) [*3] |-> !d_out_reg[g].tru_oe && !d_out_reg[g].cmp_oe)
                else $error("disabled pair not floating");
            stop_drive_a: assert property (
                mode_reg[g] == cpc_pkg::DM_STOP |=> d_out_reg[g].tru &&
                !d_out_reg[g].cmp && d_out_reg[g].bias == `CPC_BIAS_X6)
                else $error("stopped pair not at x6 high");
            sleep_drive_a: assert property (
                mode_reg[g] == cpc_pkg::DM_PD |=> d_out_reg[g].tru_oe &&
                !d_out_reg[g].cmp_oe && d_out_reg[g].bias == `CPC_BIAS_X2)
                else $error("sleeping pair not at x2");
            mode_edge_a: assert property (
                $changed(mode_reg[g]) && $past(d_oe[g]) |-> $past(d_raw[g]))
                else $error("pair mode changed with true leg low");
        end
    endgenerate

    assign cpu_clk_o           = d_out_reg[2:0];
    assign pcie_ref_clock_o    = d_out_reg[3];
    assign display_96m_clock_o = d_out_reg[4];

    // single-ended: periph bus, two free, usb, ref
    always_comb begin
        for (int k = 0; k < NSE; k++) begin
            se_raw[k]  = raw[3];
            se_stop[k] = pd_hold;
        end
        for (int k = 0; k < NPB; k++) begin
            se_stop[k] = pd_hold || periph_stop;
        end
        for (int k = 0; k < 2; k++) begin
            se_stop[NPB+k] = pd_hold || (periph_stop &&
                             !pcie_ctrl_reg[`CPC_F_FREE_AON+k]);
        end
        se_raw[NPB+2] = raw[4];
        se_raw[NPB+3] = raw[5];
    end

    // gate changes only while the raw clock is low: clean stop and start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            se_gate_reg <= '0;
            se_out_reg  <= '0;
        end else begin
            for (int k = 0; k < NSE; k++) begin
                if (!se_raw[k]) begin
                    se_gate_reg[k] <= !se_stop[k];
                end
                se_out_reg[k] <= se_raw[k] & se_gate_reg[k];
            end
        end
    end

    assign periph_bus_clk_o    = se_out_reg[NPB-1:0];
    assign periph_free_clock_o = se_out_reg[NPB+1:NPB];
    assign usb_clk_o           = se_out_reg[NPB+2];
    assign ref_clk_o           = se_out_reg[NPB+3];

    vco_stop_order_a: assert property (
        $fell(vco_en_reg) |-> $past(se_out_reg) == '0 && $past(&d_parked))
        else $error("vco stopped before outputs parked");
    off_outputs_a: assert property (
        state_reg == cpc_pkg::PS_OFF |-> se_out_reg == '0 &&
        !d_out_reg[0].cmp_oe && !d_out_reg[3].cmp_oe && !d_out_reg[4].cmp_oe)
        else $error("output active while vco off");
    se_no_runt_a: assert property (
        $rose(se_out_reg[0]) |-> $past(se_raw[0]) && !$past(se_raw[0], 2))
        else $error("periph bus rose without raw edge");
    wake_lock_a: assert property (
        state_reg == cpc_pkg::PS_RUN && $past(state_reg) == cpc_pkg::PS_WAKE
        |-> $past(lock_reg) == 16'(LOCK_CYC))
        else $error("outputs released before lock time");
    periph_park_a: assert property (
        se_stop[0] && !se_raw[0] |=> !se_out_reg[0] && !se_gate_reg[0])
        else $error("periph bus not held low");
    free_aon_a: assert property (
        !pd_hold && pcie_ctrl_reg[`CPC_F_FREE_AON] |-> !se_stop[NPB])
        else $error("always-on free clock stopped");
    disp_runs_a: assert property (
        !pd_hold && d_oe[4] && mode_reg[4] == cpc_pkg::DM_RUN |=>
        mode_reg[4] == cpc_pkg::DM_RUN) else $error("display stopped awake");
    cpu_halt_a: assert property (
        cpu_halt && !pd_hold && d_oe[0] && !d_aon[0] && d_raw[0] |=>
        mode_reg[0] != cpc_pkg::DM_RUN) else $error("cpu pair kept running");
endmodule

// [cpc_pm_model.sv]
// power-management partner that drives the power-down and halt pins
`timescale 1ns/1ps
module cpc_pm_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       pd_req_i,
    input  wire logic       halt_req_i,
    input  wire logic       periph_req_i,
    input  wire logic [3:0] lag_i,
    output logic            power_down_pin_o,
    output logic            cpu_halt_n_o,
    output logic            periph_halt_n_o
);
    logic [15:0][2:0] line_reg;

    // requests reach the pins lag_i + 1 cycles late, unrelated to output clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_reg <= '0;
        end else begin
            line_reg <= {line_reg[14:0], {pd_req_i, halt_req_i, periph_req_i}};
        end
    end

    assign power_down_pin_o = line_reg[lag_i][2];
    assign cpu_halt_n_o     = ~line_reg[lag_i][1];
    assign periph_halt_n_o  = ~line_reg[lag_i][0];
endmodule

// [test_clock_output_powerdown_stop_control.sv]
// self-checking bench of the clock output power-down and stop control
`timescale 1ns/1ps
`include "cpc_cfg.svh"
module test_clock_output_powerdown_stop_control;
    logic                     clk_i, rst_i, cyc, stb, we, ack, vco;
    logic                     pd_pin, halt_n, ph_n, pd_req, h_req, p_req;
    logic [3:0]               lag;
    logic [7:0]               adr;
    logic [31:0]              wdat, rdat, q;
    logic [5:0]               pb;
    logic [1:0]               pf;
    logic                     usb, rclk;
    cpc_pkg::cpc_diff_t [2:0] cpu;
    cpc_pkg::cpc_diff_t       pcie, disp;
    logic [14:0]              vec, hi, lo;
    int                       fails, compares, hlen, llen;

    cpc_pm_model pm_u (.clk_i(clk_i), .rst_i(rst_i), .pd_req_i(pd_req),
        .halt_req_i(h_req), .periph_req_i(p_req), .lag_i(lag),
        .power_down_pin_o(pd_pin), .cpu_halt_n_o(halt_n),
        .periph_halt_n_o(ph_n));

    cpc_top #(.NPB(6), .LOCK_CYC(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .power_down_pin_i(pd_pin), .cpu_halt_n_i(halt_n),
        .periph_halt_n_i(ph_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h3),
        .wb_dat_o(rdat), .wb_ack_o(ack), .vco_en_o(vco), .cpu_clk_o(cpu),
        .pcie_ref_clock_o(pcie), .display_96m_clock_o(disp),
        .periph_bus_clk_o(pb), .periph_free_clock_o(pf), .usb_clk_o(usb),
        .ref_clk_o(rclk));

    assign vec = {disp.tru, pcie.tru, cpu[2].tru, cpu[1].tru, cpu[0].tru,
                  rclk, usb, pf, pb};

    task finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle; ack is read at the edge that completes it
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            finish_test;
        end
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        wb(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask

    task watch(input int n);
        hi = '0;
        lo = '0;
        repeat (n) begin
            @(posedge clk_i);
            hi |= vec;
            lo |= ~vec;
        end
    endtask

    task wait_run;
        int n;
        n = 0;
        do begin
            wb(1'b0, `CPC_OFS_STATUS, 32'h0);
            n++;
        end while (q[7:4] !== 4'h1 && n < 60);
        if (q[7:4] !== 4'h1) begin
            fails++;
            finish_test;
        end
    endtask

    // a high or low run shorter than the divider half period is a runt
    always @(posedge clk_i) begin
        if (rst_i) begin
            hlen <= 0;
            llen <= `CPC_HALF_USB;
        end else if (usb) begin
            if (llen != 0) check("usb low run", llen >= `CPC_HALF_USB, 1);
            hlen <= hlen + 1;
            llen <= 0;
        end else begin
            if (hlen != 0) check("usb high run", hlen, `CPC_HALF_USB);
            llen <= llen + 1;
            hlen <= 0;
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0;
        wdat = '0; pd_req = 1'b0; h_req = 1'b0; p_req = 1'b0; lag = 4'h0;
        fails = 0; compares = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`CPC_OFS_CPU_CTRL, 32'h111, "cpu ctrl reset");
        rd(`CPC_OFS_PCIE_CTRL, 32'h01, "pcie ctrl reset");
        rd(`CPC_OFS_DISP_CTRL, 32'h1, "disp ctrl reset");
        wb(1'b1, 8'h10, 32'hffff);
        rd(8'h10, 32'h0, "unmapped read");
        wait_run;
        watch(60);
        check("run toggles", 32'(hi & lo), 32'h7fff);
        $display("test reset done");
        // cpu0 parks at x6, cpu1 floats, cpu2 always on
        wb(1'b1, `CPC_OFS_CPU_CTRL, 32'h951);
        lag <= 4'h5;
        h_req <= 1'b1;
        repeat (30) @(posedge clk_i);
        watch(60);
        check("halt toggles", 32'(hi & lo), 32'h73ff);
        check("cpu0 parked", {cpu[0].tru, cpu[0].cmp, cpu[0].bias},
              {2'b10, `CPC_BIAS_X6});
        check("cpu1 float", {cpu[1].tru_oe, cpu[1].cmp_oe}, 2'b00);
        check("cpu2 bias", cpu[2].bias, `CPC_BIAS_NORM);
        rd(`CPC_OFS_STATUS, 32'h1a, "halt status");
        h_req <= 1'b0;
        repeat (30) @(posedge clk_i);
        watch(60);
        check("halt release", 32'(hi[10] & lo[10]), 32'h1);
        $display("test cpu halt done");
        // periph halt from the pin, then from the bit with pcie floated
        for (int s = 0; s < 2; s++) begin
            lag <= 4'(s);
            wb(1'b1, `CPC_OFS_PCIE_CTRL, s ? 32'h35 : 32'h21);
            p_req <= (s == 0);
            repeat (30) @(posedge clk_i);
            watch(60);
            check("periph low", 32'({hi[7], hi[5:0]}), 32'h0);
            check("free aon", 32'(hi[6] & lo[6]), 32'h1);
            check("pcie parked", {pcie.tru, pcie.tru_oe, pcie.bias},
                  s ? {2'b00, `CPC_BIAS_OFF} : {2'b11, `CPC_BIAS_X6});
            wb(1'b1, `CPC_OFS_PCIE_CTRL, 32'h21);
            p_req <= 1'b0;
            repeat (30) @(posedge clk_i);
            watch(60);
            check("periph resume", 32'(hi & lo), 32'h7fff);
        end
        $display("test periph halt done");
        // power-down: cpu0 x2, cpu1 sleep float, cpu2 disabled
        wb(1'b1, `CPC_OFS_CPU_CTRL, 32'h031);
        wb(1'b1, `CPC_OFS_DISP_CTRL, 32'h3);
        lag <= 4'h3;
        pd_req <= 1'b1;
        for (int n = 0; n < 300 && vco !== 1'b0; n++) @(posedge clk_i);
        check("vco off", vco, 1'b0);
        watch(40);
        check("se low", 32'(hi[9:0]), 32'h0);
        check("cpu0 sleep", {cpu[0].tru, cpu[0].tru_oe, cpu[0].cmp_oe,
              cpu[0].bias}, {3'b110, `CPC_BIAS_X2});
        check("cpu1 float", cpu[1].tru_oe, 1'b0);
        check("cpu2 off", {cpu[2].tru_oe, cpu[2].cmp_oe}, 2'b00);
        check("disp float", disp.tru_oe, 1'b0);
        check("pcie sleep", pcie.bias, `CPC_BIAS_X2);
        rd(`CPC_OFS_STATUS, 32'h41, "pd status");
        pd_req <= 1'b0;
        wait_run;
        check("vco on", vco, 1'b1);
        watch(60);
        check("wake toggles", 32'(hi & lo), 32'h6fff);
        check("cpu2 still off", cpu[2].tru_oe, 1'b0);
        $display("test power down done");
        finish_test;
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        finish_test;
    end
endmodule
